/* File: core/open_load_on_summary_pkg.sv */
// Package for the open-load-at-on diagnosis sequencer
package open_load_on_summary_pkg;

  // Channel count and selector codes
  localparam int          NUM_CH       = 8;
  localparam logic [3:0]  SEL_LOOP     = 4'hA;
  localparam logic [3:0]  SEL_DEFAULT  = 4'hF;
  localparam logic [3:0]  SEL_CH_LAST  = 4'h7;
  localparam logic [3:0]  SEL_CH_MSB   = 4'h8;

  // Clock rate and delays, nanoseconds per cycle, microsecond figures and a sync delay in cycles
  localparam int CLK_NS           = 5;
  localparam int SETTLE_US        = 40;
  localparam int SWITCH_US        = 20;
  localparam int ON_WAIT_US       = 76;
  localparam int SYNC_CYC_DEF     = 4;

  // Cycle counts round down, with no floor of one cycle
  localparam int SETTLE_CYC_DEF   = (SETTLE_US * 1000) / CLK_NS;
  localparam int SWITCH_CYC_DEF   = (SWITCH_US * 1000) / CLK_NS;
  localparam int ON_WAIT_CYC_DEF  = (ON_WAIT_US * 1000) / CLK_NS;

  // Counter width covers the longest wait
  localparam int CNT_W            = 16;

  // Sequencer states
  typedef enum logic [2:0] {
    OPEN_LOAD_ON_SUMMARY_IDLE,
    OPEN_LOAD_ON_SUMMARY_SINGLE,
    OPEN_LOAD_ON_SUMMARY_DIRECT,
    OPEN_LOAD_ON_SUMMARY_PWM_SETTLE,
    OPEN_LOAD_ON_SUMMARY_PWM_ARM,
    OPEN_LOAD_ON_SUMMARY_PWM_MEASURE
  } open_load_on_summary_state_t;

  // Whole module state
  typedef struct packed {
    open_load_on_summary_state_t       state;
    logic [3:0]        sel;
    logic [2:0]        chan;
    logic [CNT_W-1:0]  cnt;
    logic              pwmPass;
    logic [7:0]        done;
    logic [7:0]        result;
    logic              summary;
    logic [2:0]        cmpSync;
    logic              cmpLevel;
  } open_load_on_summary_regs_t;

endpackage : open_load_on_summary_pkg

/* File: core/open_load_on_summary_sequencer.sv */
// Open-load-at-on diagnosis sequencer for an eight-channel switch
//
// How it works
// - Code 1010 starts the autonomous loop
// - Sequencer steps the multiplexer without host help
// - Direct channels first, then PWM channels
// - Direct group starts at the lowest direct channel
// - First direct result after settle plus sync
// - Next direct results after switch plus sync
// - Off direct channel gives result zero
// - Generator 0 channels before generator 1
// - First PWM waits settle, edge, on-wait, switch
// - Later same-generator PWM channels done after switch delay while the pulse stays on
// - Off PWM channel waits for next on
// - Short on pulse gives result zero
// - Loop end restores selector to 1111
// - Results hold until a new loop or single-channel code
// - Summary one means open load detected
// - Single mode summary samples selected channel on diag read
// - Loop mode summary is OR of results
// - Default mode summary is OR of the held results
// - Reserved codes force summary to zero
// - Single mode clears unselected results, refreshes on read
// - Reset leaves selector at default, diagnosis off
`timescale 1ns/1ps

module open_load_on_summary_sequencer #(
  parameter int SETTLE_CYC  = open_load_on_summary_pkg::SETTLE_CYC_DEF,
  parameter int SWITCH_CYC  = open_load_on_summary_pkg::SWITCH_CYC_DEF,
  parameter int ON_WAIT_CYC = open_load_on_summary_pkg::ON_WAIT_CYC_DEF,
  parameter int SYNC_CYC    = open_load_on_summary_pkg::SYNC_CYC_DEF
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Host selector write
  input  wire logic        selWrite,
  input  wire logic [3:0]  selValue,
  // Read strobes from the host side
  input  wire logic        resultRead,
  input  wire logic        stdDiagRead,
  // Channel state
  input  wire logic [7:0]  channelOn,
  input  wire logic [7:0]  pwmMapped,
  input  wire logic [7:0]  pwmGenSel,
  // Analog comparator, asynchronous
  input  wire logic        openLoadCmp,
  // Multiplexer and results
  output logic [2:0]       muxChannel,
  output logic [3:0]       open_load_on_select,
  output logic [7:0]       open_load_on_result_reg,
  output logic             open_load_on_summary,
  output logic             loopBusy
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [open_load_on_summary_pkg::CNT_W-1:0] SETTLE_N =
    open_load_on_summary_pkg::CNT_W'(SETTLE_CYC + SYNC_CYC);
  localparam logic [open_load_on_summary_pkg::CNT_W-1:0] SWSYNC_N =
    open_load_on_summary_pkg::CNT_W'(SWITCH_CYC + SYNC_CYC);
  localparam logic [open_load_on_summary_pkg::CNT_W-1:0] SETTLEONLY_N =
    open_load_on_summary_pkg::CNT_W'(SETTLE_CYC);
  localparam logic [open_load_on_summary_pkg::CNT_W-1:0] SW_N =
    open_load_on_summary_pkg::CNT_W'(SWITCH_CYC);
  localparam logic [open_load_on_summary_pkg::CNT_W-1:0] ONSW_N =
    open_load_on_summary_pkg::CNT_W'(ON_WAIT_CYC + SWITCH_CYC);

  open_load_on_summary_pkg::open_load_on_summary_regs_t r_q;
  open_load_on_summary_pkg::open_load_on_summary_regs_t r_d;

  // Channel class lookups
  logic [7:0] directSet;
  logic [7:0] pwm0Set;
  logic [7:0] pwm1Set;
  assign directSet = ~pwmMapped;
  assign pwm0Set   = pwmMapped & ~pwmGenSel;
  assign pwm1Set   = pwmMapped & pwmGenSel;

  // Lowest pending channel of a set, as a function; 8 when none
  function automatic logic [3:0] nextIn(input logic [7:0] set,
                                        input logic [7:0] doneMask);
    logic [3:0] found;
    found = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (set[i] && !doneMask[i]) begin
        found = 4'(i);
      end
    end
    return found;
  endfunction : nextIn

  // Next PWM channel once the direct group is done: generator 0 first
  logic [3:0] nextPwm;
  assign nextPwm    = (nextIn(pwm0Set, r_q.done) != 4'h8) ?
                      nextIn(pwm0Set, r_q.done) :
                      nextIn(pwm1Set, r_q.done);

  logic chanOn;
  logic cntZero;
  assign chanOn  = channelOn[r_q.chan];
  assign cntZero = (r_q.cnt == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Scratch for channel searches
    logic [3:0] pick;
    pick = 4'h8;
    r_d = r_q;
    // Three-stage sync; second and third must agree before level moves
    r_d.cmpSync = {r_q.cmpSync[1:0], openLoadCmp};
    if (r_q.cmpSync[2] == r_q.cmpSync[1]) begin
      r_d.cmpLevel = r_q.cmpSync[2];
    end
    if (!cntZero) begin
      r_d.cnt = r_q.cnt - 1'b1;
    end

    // Host write of the selector
    if (selWrite) begin
      r_d.sel = selValue;
      if (selValue == open_load_on_summary_pkg::SEL_LOOP) begin
        r_d.state  = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_DIRECT;
        r_d.done   = '0;
        r_d.result = '0;
        r_d.cnt    = SETTLE_N;
        r_d.pwmPass = 1'b0;
        // Search from scratch; last loop's done bits must not leak in
        pick       = nextIn(directSet, 8'h00);
        r_d.chan   = pick[2:0];
        if (pick == 4'h8) begin
          // No direct channel: go straight to the PWM group
          pick = nextIn(pwm0Set, 8'h00);
          if (pick == 4'h8) begin
            pick = nextIn(pwm1Set, 8'h00);
          end
          r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_SETTLE;
          r_d.chan  = pick[2:0];
          r_d.cnt   = SETTLEONLY_N;
        end
      end else if (selValue <= open_load_on_summary_pkg::SEL_CH_LAST) begin
        r_d.state  = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_SINGLE;
        r_d.chan   = selValue[2:0];
        r_d.cnt    = SETTLE_N;
        r_d.result = '0;
      end else begin
        r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE;
      end
    end else begin
      case (r_q.state)
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE: begin
        end
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_SINGLE: begin
          // Result refreshed on each register read after settling
          if (cntZero && resultRead) begin
            r_d.result = '0;
            r_d.result[r_q.chan] = chanOn & r_q.cmpLevel;
          end
        end
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_DIRECT: begin
          if (cntZero) begin
            r_d.result[r_q.chan] = chanOn & r_q.cmpLevel;
            r_d.done[r_q.chan]   = 1'b1;
            r_d.cnt              = SWSYNC_N;
            pick = nextIn(directSet, r_d.done);
            if (pick != 4'h8) begin
              r_d.chan = pick[2:0];
            end else if (pwmMapped != 8'h00) begin
              r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_SETTLE;
              r_d.chan  = nextPwm[2:0];
              r_d.cnt   = SETTLEONLY_N;
            end else begin
              r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE;
              r_d.sel   = open_load_on_summary_pkg::SEL_DEFAULT;
            end
          end
        end
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_SETTLE: begin
          // Wait for a fresh switch-on edge once settled
          if (cntZero && !chanOn) begin
            r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_ARM;
          end
        end
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_ARM: begin
          if (chanOn) begin
            r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE;
            r_d.cnt   = r_q.pwmPass ? SW_N : ONSW_N;
          end
        end
        open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE: begin
          if (!chanOn || cntZero) begin
            // Dropping early means a short pulse: write zero
            r_d.result[r_q.chan] = chanOn & r_q.cmpLevel;
            r_d.done[r_q.chan]   = 1'b1;
            r_d.pwmPass          = chanOn;
            pick = nextIn(pwm0Set, r_d.done);
            if (pick == 4'h8) begin
              pick = nextIn(pwm1Set, r_d.done);
            end
            if (pick == 4'h8) begin
              r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE;
              r_d.sel   = open_load_on_summary_pkg::SEL_DEFAULT;
            end else begin
              r_d.chan = pick[2:0];
              if (pwmGenSel[pick[2:0]] != pwmGenSel[r_q.chan]) begin
                // Other generator runs its own period: new on edge
                r_d.state   = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_SETTLE;
                r_d.cnt     = '0;
                r_d.pwmPass = 1'b0;
              end else if (chanOn && channelOn[pick[2:0]]) begin
                // Same pulse still on, so the switch delay suffices
                r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE;
                r_d.cnt   = SW_N;
              end else begin
                r_d.state   = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_ARM;
                r_d.pwmPass = 1'b0;
              end
            end
          end
        end
        default: r_d.state = open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE;
      endcase
    end

    // Summary bit per selector code
    if (r_d.sel <= open_load_on_summary_pkg::SEL_CH_LAST) begin
      if (stdDiagRead) begin
        r_d.summary = r_d.result[r_d.sel[2:0]];
      end
    end else if (r_d.sel == open_load_on_summary_pkg::SEL_LOOP) begin
      r_d.summary = |r_d.result;
    end else if (r_d.sel == open_load_on_summary_pkg::SEL_DEFAULT) begin
      r_d.summary = |r_d.result;
    end else begin
      r_d.summary = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves diagnosis idle at default code
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '{state: open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE, sel: open_load_on_summary_pkg::SEL_DEFAULT,
               default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops; loopBusy decoded from the selector
  assign muxChannel              = r_q.chan;
  assign open_load_on_select     = r_q.sel;
  assign open_load_on_result_reg = r_q.result;
  assign open_load_on_summary    = r_q.summary;
  assign loopBusy                = (r_q.sel == open_load_on_summary_pkg::SEL_LOOP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_loop_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    selWrite && selValue == open_load_on_summary_pkg::SEL_LOOP && directSet[0] |=>
      muxChannel == 3'h0 && r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_DIRECT)
    else $error("loop did not start at channel zero");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (open_load_on_select > open_load_on_summary_pkg::SEL_CH_LAST &&
     open_load_on_select != open_load_on_summary_pkg::SEL_LOOP &&
     open_load_on_select != open_load_on_summary_pkg::SEL_DEFAULT) |-> !open_load_on_summary)
    else $error("summary not zero for reserved code");

  a_loop_or: assert property (@(posedge core_clk) disable iff (!reset_n)
    open_load_on_select == open_load_on_summary_pkg::SEL_LOOP |->
      open_load_on_summary == |open_load_on_result_reg)
    else $error("summary is not OR of results");

  a_hold_result: assert property (@(posedge core_clk) disable iff (!reset_n)
    open_load_on_select == open_load_on_summary_pkg::SEL_DEFAULT && !selWrite |=>
      $stable(open_load_on_result_reg))
    else $error("results changed outside a loop");

  a_single_others: assert property (@(posedge core_clk) disable iff (!reset_n)
    open_load_on_select <= open_load_on_summary_pkg::SEL_CH_LAST |->
      (open_load_on_result_reg &
       ~(8'h01 << open_load_on_select[2:0])) == 8'h00)
    else $error("unselected result not zero");

  a_direct_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    selWrite && selValue == open_load_on_summary_pkg::SEL_LOOP && directSet[0] |=>
      (open_load_on_result_reg == 8'h00)[*8])
    else $error("first direct result updated too early");

  a_off_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_DIRECT && cntZero && !chanOn && !selWrite
      |=> !open_load_on_result_reg[$past(r_q.chan)])
    else $error("off channel result not zero");

  a_loop_end: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.state != open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE && r_q.state != open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_SINGLE
      && r_d.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_IDLE && !selWrite
      |=> open_load_on_select == open_load_on_summary_pkg::SEL_DEFAULT)
    else $error("selector not restored after loop");

  ////////////////////////////////////////////////////////////////////////////
  // Loop order, PWM, single summary and comparator checks

  a_short_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE && !chanOn && !selWrite
      |=> !open_load_on_result_reg[$past(r_q.chan)])
    else $error("short pulse result not zero");

  a_direct_first: assert property (@(posedge core_clk) disable iff (!reset_n)
    (r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_SETTLE ||
     r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_ARM ||
     r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE) |->
      (directSet & ~r_q.done) == 8'h00)
    else $error("PWM channel checked before a direct one");

  a_gen_order: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE && pwm1Set[r_q.chan] |->
      (pwm0Set & ~r_q.done) == 8'h00)
    else $error("generator 1 channel before generator 0");

  a_mux_steady: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_DIRECT && !cntZero && !selWrite |=>
      $stable(muxChannel))
    else $error("multiplexer moved before the check ended");

  a_single_sum: assert property (@(posedge core_clk) disable iff (!reset_n)
    open_load_on_select <= open_load_on_summary_pkg::SEL_CH_LAST && stdDiagRead && !selWrite
      |=> open_load_on_summary ==
          open_load_on_result_reg[open_load_on_select[2:0]])
    else $error("single summary does not mirror the result");

  // PWM trigger: the switch-on edge starts the long wait
  sequence s_pwm_edge;
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_ARM && chanOn && !r_q.pwmPass
      && !selWrite;
  endsequence

  sequence s_pwm_wait;
    r_q.state == open_load_on_summary_pkg::OPEN_LOAD_ON_SUMMARY_PWM_MEASURE && r_q.cnt == ONSW_N;
  endsequence

  a_pwm_trigger: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_pwm_edge |=> s_pwm_wait)
    else $error("PWM wait not started on the switch-on edge");

  a_cmp_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    r_q.cmpSync[2] != r_q.cmpSync[1] |=> $stable(r_q.cmpLevel))
    else $error("comparator level moved while stages disagree");

endmodule : open_load_on_summary_sequencer

/* File: verification/open_load_on_summary_host_model.sv */
// Host model: selector writes and read strobes toward the sequencer
`timescale 1ns/1ps

module open_load_on_summary_host_model (
  // Clock
  input  wire logic  core_clk,
  // Strobes toward the sequencer
  output logic       selWrite,
  output logic [3:0] selValue,
  output logic       resultRead,
  output logic       stdDiagRead
);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet at time zero
  initial begin
    selWrite = 1'b0;
    selValue = 4'h5;
    resultRead = 1'b0;
    stdDiagRead = 1'b0;
  end

  // One-cycle write; code is scrambled after release so stale data shows
  task automatic write_sel(input logic [3:0] code);
    @(posedge core_clk);
    #1;
    selWrite = 1'b1;
    selValue = code;
    @(posedge core_clk);
    #1;
    selWrite = 1'b0;
    selValue = ~code;
  endtask : write_sel

  // One-cycle read strobe of result or summary
  task automatic read_pulse(input logic diag);
    @(posedge core_clk);
    #1;
    if (diag) stdDiagRead = 1'b1;
    else resultRead = 1'b1;
    @(posedge core_clk);
    #1;
    stdDiagRead = 1'b0;
    resultRead = 1'b0;
  endtask : read_pulse
endmodule : open_load_on_summary_host_model

/* File: verification/open_load_on_diag_sequencer_test.sv */
// Self-checking bench for the open-load-at-on sequencer
`timescale 1ns/1ps

module open_load_on_diag_sequencer_test;
  logic       core_clk, reset_n, selWrite, resultRead, stdDiagRead;
  logic [3:0] selValue, selOut;
  logic [7:0] channelOn, pwmMapped, pwmGenSel, dirOn, shortMask, lastRes;
  logic [7:0] resReg;
  logic       openLoadCmp, summary, loopBusy, wasBusy;
  logic [2:0] muxChannel, lastMux;
  logic [2:0] muxQ[$];
  logic [3:0] rsv[6] = '{4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE};
  int         n_fail, total_checks, seed, ph, r;

  open_load_on_summary_host_model host (.core_clk(core_clk), .selWrite(selWrite),
    .selValue(selValue), .resultRead(resultRead), .stdDiagRead(stdDiagRead));

  // Short delays keep the run brief
  open_load_on_summary_sequencer #(.SETTLE_CYC(10), .SWITCH_CYC(5), .ON_WAIT_CYC(20))
    uut (.core_clk(core_clk), .reset_n(reset_n),
    .selWrite(selWrite), .selValue(selValue), .resultRead(resultRead),
    .stdDiagRead(stdDiagRead), .channelOn(channelOn),
    .pwmMapped(pwmMapped), .pwmGenSel(pwmGenSel),
    .openLoadCmp(openLoadCmp), .muxChannel(muxChannel),
    .open_load_on_select(selOut), .open_load_on_result_reg(resReg),
    .open_load_on_summary(summary), .loopBusy(loopBusy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    n_fail++;
    $display("MISMATCH t=%0t %s", $time, msg);
  endtask : fail

  task automatic chk_vec(input logic [7:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask : chk_vec

  task automatic chk_mux(input logic [2:0] got, exp);
    total_checks++;
    if (got !== exp) fail($sformatf("mux got %0d exp %0d", got, exp));
  endtask : chk_mux

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Single channel: result only after a read, summary after diag read
  task automatic single(input logic [3:0] ch, input logic on, cmp);
    dirOn = on ? (8'h01 << ch[2:0]) : 8'h00;
    openLoadCmp = cmp;
    host.write_sel(ch);
    tick(20);
    host.read_pulse(1'b0);
    host.read_pulse(1'b1);
    tick(3);
    chk_vec(resReg, (on && cmp) ? (8'h01 << ch[2:0]) : 8'h00, "one");
    chk_vec({7'h0, summary}, {7'h0, on && cmp}, "one sum");
  endtask : single

  // Loop: expected mux order queued, results checked at the end
  task automatic run_loop(input logic [7:0] dir, map, gen, shrt);
    int n;
    dirOn = dir;
    pwmMapped = map;
    pwmGenSel = gen;
    shortMask = shrt;
    for (int i = 0; i < 8; i++) if (!map[i]) muxQ.push_back(i[2:0]);
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 8; i++)
        if (map[i] && gen[i] == k[0]) muxQ.push_back(i[2:0]);
    lastRes = (dir & ~map) | (map & ~shrt);
    n = 0;
    host.write_sel(open_load_on_summary_pkg::SEL_LOOP);
    while (loopBusy !== 1'b0 && n < 6000) begin
      tick(1);
      n++;
    end
    if (n >= 6000) fail("loop hang");
    tick(2);
    chk_vec(resReg, lastRes, "loop");
    chk_vec({selOut, 4'h0}, {open_load_on_summary_pkg::SEL_DEFAULT, 4'h0}, "sel");
    chk_vec({7'h0, summary}, {7'h0, |lastRes}, "sum");
    chk_vec({7'h0, muxQ.size() == 0}, 8'h01, "steps left");
  endtask : run_loop

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #2.5 core_clk = ~core_clk;

  // PWM channels: long pulses, or pulses too short to measure
  always @(posedge core_clk) begin
    ph <= ph + 1;
    channelOn <= #1 (dirOn & ~pwmMapped)
      | (pwmMapped & ~shortMask & {8{(ph % 400) < 380}})
      | (pwmMapped & shortMask & {8{(ph % 40) < 10}});
  end

  // Each new multiplexer step must match the oldest queued channel
  always @(posedge core_clk) begin
    if (loopBusy === 1'b1 && (wasBusy !== 1'b1 || muxChannel !== lastMux))
    begin
      if (muxQ.size() == 0) fail("extra mux step");
      else chk_mux(muxChannel, muxQ.pop_front());
    end
    wasBusy <= loopBusy;
    lastMux <= muxChannel;
  end

  // Watchdog sized well past the expected run
  initial begin
    #400000;
    fail("watchdog");
    final_report();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    openLoadCmp = 1'b1;
    {dirOn, pwmMapped, pwmGenSel, shortMask} = '0;
    seed = 91066;
    tick(20);
    reset_n = 1'b1;
    tick(1);
    chk_vec({selOut, 3'h0, loopBusy}, 8'hF0, "reset");
    chk_vec({resReg[6:0], summary}, 8'h00, "reset res");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      single(i[3:0], r[0], r[1]);
    end
    $display("test single done");
    r = $random(seed);
    run_loop(r[7:0], 8'h00, 8'h00, 8'h00);
    openLoadCmp = 1'b0;
    host.read_pulse(1'b0);
    host.read_pulse(1'b1);
    tick(8);
    chk_vec(resReg, lastRes, "hold");
    chk_vec({7'h0, summary}, {7'h0, |lastRes}, "hold sum");
    openLoadCmp = 1'b1;
    $display("test direct loop done");
    foreach (rsv[j]) begin
      host.write_sel(rsv[j]);
      tick(2);
      chk_vec({selOut, 3'h0, summary}, {rsv[j], 4'h0}, "rsv");
    end
    $display("test reserved done");
    r = $random(seed);
    // Short pulses ride alone on generator 1: one generator, one pulse
    run_loop(r[7:0], 8'h66, 8'h40, 8'h40);
    $display("test pwm loop done");
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    chk_vec({selOut, 3'h0, loopBusy}, 8'hF0, "mid reset");
    chk_vec(resReg, 8'h00, "mid reset res");
    $display("test mid reset done");
    final_report();
  end
endmodule : open_load_on_diag_sequencer_test
